//--- verilog/eps_pkg.sv
package eps_pkg;

  // ----------------------------------------------------------------
  // Pin function selects
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EPS_FN_EEPROM  = 2'h0,
    EPS_FN_GENERAL = 2'h1,
    EPS_FN_MON_A   = 2'h2,
    EPS_FN_MON_B   = 2'h3
  } eps_fn_t;

  // ----------------------------------------------------------------
  // Reset values and other constants
  // ----------------------------------------------------------------
  localparam logic [1:0] EPS_FN_RESET    = 2'h0;
  localparam logic       EPS_GPO_RESET   = 1'h0;
  localparam logic       EPS_SEL_IDLE    = 1'h0;
  localparam logic       EPS_STRAP_RESET = 1'h0;
  localparam logic       EPS_WIDTH_32    = 1'h1;
  localparam logic       EPS_WIDTH_16    = 1'h0;
  localparam logic [1:0] EPS_RELEASE_CNT = 2'h2;

endpackage : eps_pkg

//--- verilog/eps_sync.sv
`timescale 1ns/1ps

module eps_sync
(
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);

  logic stage1;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage1 <= 1'h0;
      o_sync <= 1'h0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : eps_sync

//--- verilog/eps_top.sv
// How it works
// - Data pin is EEPROM data by default
// - Data pin: general output or transmit monitor
// - Data pin repurposed forces select deasserted
// - Clock pin: general output or receive monitor
// - Clock pin repurposed forces select deasserted
// - No general input on either pin
// - Strap sampled on the third clock after reset release, held
// - Strap high 32-bit, low 16-bit
`timescale 1ns/1ps

module eps_top
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [1:0] i_data_pin_fn,
  input  wire logic [1:0] i_clock_pin_fn,
  input  wire logic       i_general_output_three,
  input  wire logic       i_general_output_four,
  input  wire logic       i_mii_tx_en,
  input  wire logic       i_mii_tx_clk,
  input  wire logic       i_mii_rx_dv,
  input  wire logic       i_mii_rx_clk,
  input  wire logic       i_ee_data_out,
  input  wire logic       i_ee_data_oe,
  input  wire logic       i_ee_clock,
  input  wire logic       i_ee_select,
  input  wire logic       i_eeprom_serial_data_pin,
  output logic            o_eeprom_serial_data_pin,
  output logic            o_eeprom_serial_data_pin_oe,
  output logic            o_eeprom_serial_clock_pin,
  output logic            o_eeprom_select,
  output logic            o_ee_data_in,
  output logic            o_bus_width_strap,
  output logic            o_bus_is_32bit,
  output logic            o_strap_valid
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic data_pin_sync;
  logic tx_en_s;
  logic tx_clk_s;
  logic rx_dv_s;
  logic rx_clk_s;

  eps_sync u_sync_data
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_eeprom_serial_data_pin),
    .o_sync    (data_pin_sync)
  );

  // Monitor sources share the same clock, so no synchroniser; a
  // monitored MII clock is only seen as well as i_clk can sample it.
  assign tx_en_s  = i_mii_tx_en;
  assign tx_clk_s = i_mii_tx_clk;
  assign rx_dv_s  = i_mii_rx_dv;
  assign rx_clk_s = i_mii_rx_clk;

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  function automatic logic fn_repurposed(input logic [1:0] fn);
    fn_repurposed = (fn != eps_pkg::EPS_FN_EEPROM);
  endfunction : fn_repurposed

  logic data_alt;
  logic clock_alt;

  assign data_alt  = fn_repurposed(i_data_pin_fn);
  assign clock_alt = fn_repurposed(i_clock_pin_fn);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [1:0] release_cnt;

  // Wait for the synchroniser to fill before taking the strap level.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      release_cnt <= 2'h0;
    else if (release_cnt != eps_pkg::EPS_RELEASE_CNT)
      release_cnt <= release_cnt + 2'h1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_bus_width_strap <= eps_pkg::EPS_STRAP_RESET;
      o_bus_is_32bit    <= eps_pkg::EPS_WIDTH_16;
      o_strap_valid     <= 1'h0;
    end
    else if (release_cnt == eps_pkg::EPS_RELEASE_CNT && !o_strap_valid)
    begin
      o_bus_width_strap <= data_pin_sync;
      o_bus_is_32bit    <= data_pin_sync ? eps_pkg::EPS_WIDTH_32 : eps_pkg::EPS_WIDTH_16;
      o_strap_valid     <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Data pin
  // ----------------------------------------------------------------
  // Pin stays released until the strap is taken so the board level wins.
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_eeprom_serial_data_pin    <= eps_pkg::EPS_GPO_RESET;
      o_eeprom_serial_data_pin_oe <= 1'h0;
    end
    else
    begin
      unique case (eps_pkg::eps_fn_t'(i_data_pin_fn))
        eps_pkg::EPS_FN_EEPROM:
        begin
          o_eeprom_serial_data_pin    <= i_ee_data_out;
          o_eeprom_serial_data_pin_oe <= i_ee_data_oe & o_strap_valid;
        end
        eps_pkg::EPS_FN_GENERAL:
        begin
          o_eeprom_serial_data_pin    <= i_general_output_three;
          o_eeprom_serial_data_pin_oe <= o_strap_valid;
        end
        eps_pkg::EPS_FN_MON_A:
        begin
          o_eeprom_serial_data_pin    <= tx_en_s;
          o_eeprom_serial_data_pin_oe <= o_strap_valid;
        end
        eps_pkg::EPS_FN_MON_B:
        begin
          o_eeprom_serial_data_pin    <= tx_clk_s;
          o_eeprom_serial_data_pin_oe <= o_strap_valid;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_ee_data_in <= 1'h0;
    else
      o_ee_data_in <= data_alt ? 1'h0 : data_pin_sync;
  end

  // ----------------------------------------------------------------
  // Clock pin and select
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_eeprom_serial_clock_pin <= eps_pkg::EPS_GPO_RESET;
    else
    begin
      unique case (eps_pkg::eps_fn_t'(i_clock_pin_fn))
        eps_pkg::EPS_FN_EEPROM:  o_eeprom_serial_clock_pin <= i_ee_clock;
        eps_pkg::EPS_FN_GENERAL: o_eeprom_serial_clock_pin <= i_general_output_four;
        eps_pkg::EPS_FN_MON_A:   o_eeprom_serial_clock_pin <= rx_dv_s;
        eps_pkg::EPS_FN_MON_B:   o_eeprom_serial_clock_pin <= rx_clk_s;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_eeprom_select <= eps_pkg::EPS_SEL_IDLE;
    else if (data_alt || clock_alt)
      o_eeprom_select <= eps_pkg::EPS_SEL_IDLE;
    else
      o_eeprom_select <= i_ee_select;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SEL_DATA_ALT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(data_alt) |-> !o_eeprom_select)
    else $error("select active with data pin repurposed");

  AST_SEL_CLOCK_ALT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(clock_alt) |-> !o_eeprom_select)
    else $error("select active with clock pin repurposed");

  AST_SEL_PASS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !data_alt && !clock_alt |=> o_eeprom_select == $past(i_ee_select))
    else $error("select not passed in EEPROM use");

  AST_GPO_THREE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_data_pin_fn == eps_pkg::EPS_FN_GENERAL && o_strap_valid
    |=> o_eeprom_serial_data_pin_oe && o_eeprom_serial_data_pin == $past(i_general_output_three))
    else $error("general output three not driven");

  AST_TX_MON: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_data_pin_fn == eps_pkg::EPS_FN_MON_A |=> o_eeprom_serial_data_pin == $past(i_mii_tx_en))
    else $error("transmit enable monitor wrong");

  AST_RX_MON: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_clock_pin_fn == eps_pkg::EPS_FN_MON_B |=> o_eeprom_serial_clock_pin == $past(i_mii_rx_clk))
    else $error("receive clock monitor wrong");

  AST_NO_INPUT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    data_alt |=> !o_ee_data_in)
    else $error("input path open while repurposed");

  AST_STRAP_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_strap_valid |=> o_strap_valid && $stable(o_bus_width_strap))
    else $error("strap changed after capture");

  AST_WIDTH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_strap_valid |-> o_bus_is_32bit == o_bus_width_strap)
    else $error("bus width disagrees with strap");

  AST_STRAP_TIME: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(release_cnt == eps_pkg::EPS_RELEASE_CNT) |=> o_strap_valid)
    else $error("strap not taken on time");

  COV_STRAP_32: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_strap_valid) && o_bus_is_32bit);
  COV_STRAP_16: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_strap_valid) && !o_bus_is_32bit);
  COV_SEL_BLOCKED: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_ee_select && clock_alt ##1 !o_eeprom_select);

endmodule : eps_top

//--- verif/eps_pin_model.sv
`timescale 1ns/1ps

module eps_pin_model
(
  input  wire logic i_drive,
  input  wire logic i_oe,
  input  wire logic i_strap_level,
  output logic      o_pin
);
  // ----------------------------------------------------------------
  // Board side of the shared data pin
  // ----------------------------------------------------------------
  // Strap pull level
  // The strap resistor wins whenever the device lets go of the pin
  assign o_pin = i_oe ? i_drive : i_strap_level;
endmodule : eps_pin_model

//--- verif/eps_top_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED %s expected %b seen %b", nm, ex, got); \
    end \
  end

module eps_top_test;
  logic       i_clk = 1'h0, i_reset_n = 1'h0, strap = 1'h1;
  logic [1:0] dfn = 2'h0, cfn = 2'h0;
  logic       g3 = 0, g4 = 0, txen = 0, txclk = 0, rxdv = 0, rxclk = 0;
  logic       edo = 0, edoe = 0, eclk = 0, esel = 0;
  logic       o_dout, o_oe, o_ck, o_sel, o_din, o_strap, o_32, o_valid;
  logic       pin;
  logic [3:0] exp_v;
  logic [3:0] exp_q[$];
  int         error_cnt = 0, num_checks = 0, cycles = 0;

  always #10 i_clk = ~i_clk;

  eps_top DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_data_pin_fn(dfn),
    .i_clock_pin_fn(cfn), .i_general_output_three(g3), .i_general_output_four(g4),
    .i_mii_tx_en(txen), .i_mii_tx_clk(txclk), .i_mii_rx_dv(rxdv),
    .i_mii_rx_clk(rxclk), .i_ee_data_out(edo), .i_ee_data_oe(edoe),
    .i_ee_clock(eclk), .i_ee_select(esel), .i_eeprom_serial_data_pin(pin),
    .o_eeprom_serial_data_pin(o_dout), .o_eeprom_serial_data_pin_oe(o_oe),
    .o_eeprom_serial_clock_pin(o_ck), .o_eeprom_select(o_sel), .o_ee_data_in(o_din),
    .o_bus_width_strap(o_strap), .o_bus_is_32bit(o_32), .o_strap_valid(o_valid));

  eps_pin_model board (.i_drive(o_dout), .i_oe(o_oe), .i_strap_level(strap), .o_pin(pin));

  // ----------------------------------------------------------------
  // Expected pin outputs from the function selects
  // ----------------------------------------------------------------
  function automatic logic [3:0] expect_of();
    logic sel, ck, d, oe;
    sel = (dfn == 2'h0 && cfn == 2'h0) ? esel : 1'h0;
    ck  = (cfn == 2'h0) ? eclk : (cfn == 2'h1) ? g4 : (cfn == 2'h2) ? rxdv : rxclk;
    d   = (dfn == 2'h0) ? edo : (dfn == 2'h1) ? g3 : (dfn == 2'h2) ? txen : txclk;
    oe  = (dfn == 2'h0) ? edoe : 1'h1;
    return {sel, ck, d, oe};
  endfunction : expect_of

  // Outputs are registered, so a note made at a falling edge is due at the next rise
  always @(posedge i_clk)
  begin
    #1;
    if (exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK("select", exp_v[3], o_sel)
      `CHK("clock_pin", exp_v[2], o_ck)
      `CHK("data_oe", exp_v[0], o_oe)
      if (exp_v[0] === 1'h1)
        `CHK("data_pin", exp_v[1], o_dout)
    end
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      $display("timeout after %0d cycles", cycles);
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic do_reset(input logic lvl);
    i_reset_n = 1'h0;
    {dfn, cfn, edoe, esel} = 6'h00;
    strap = lvl;
    repeat (3) @(negedge i_clk);
    `CHK("oe_in_reset", 1'h0, o_oe)
    `CHK("valid_in_reset", 1'h0, o_valid)
    i_reset_n = 1'h1;
    repeat (4) @(negedge i_clk);
    `CHK("width_strap", lvl, o_strap)
    `CHK("bus_32", lvl, o_32)
    `CHK("strap_valid", 1'h1, o_valid)
    strap = ~lvl;
    repeat (4) @(negedge i_clk);
    `CHK("strap_held", lvl, o_strap)
    $display("test reset strap %b done", lvl);
  endtask : do_reset

  task automatic test_default();
    @(negedge i_clk);
    {dfn, cfn, edoe, esel, strap} = 7'h03;
    repeat (4) @(negedge i_clk);
    `CHK("select_default", 1'h1, o_sel)
    `CHK("data_in_pin", 1'h1, o_din)
    dfn = 2'h1;
    repeat (2) @(negedge i_clk);
    `CHK("data_in_blocked", 1'h0, o_din)
    `CHK("select_forced", 1'h0, o_sel)
    $display("test default done");
  endtask : test_default

  task automatic step_rand();
    @(negedge i_clk);
    {dfn, cfn, g3, g4, txen, txclk, rxdv, rxclk, edo, edoe, eclk, esel} = 14'($urandom());
    exp_q.push_back(expect_of());
  endtask : step_rand

  initial
  begin
    void'($urandom(30));
    do_reset(1'h1);
    test_default();
    repeat (300) step_rand();
    repeat (2) @(negedge i_clk);
    $display("test random done");
    do_reset(1'h0);
    results();
  end
endmodule : eps_top_test
